// >>> fclc_pkg.sv
// package: register map, field positions and reset values for the config lock
package fclc_pkg;
  // register byte offsets on the wishbone slave
  localparam logic [3:0] FCLC_CFG_OFF = 4'h0;    // configuration word
  localparam logic [3:0] FCLC_CTL_OFF = 4'h4;    // sequence control
  localparam logic [3:0] FCLC_STAT_OFF = 4'h8;   // access decision status
  // field positions, msb-0 numbering mapped to lsb-0 bit index (31 - n)
  localparam int FCLC_LOCK_BIT = 31;             // printed bit 0
  localparam int FCLC_FIC_BIT = 28;              // printed bit 3
  localparam int FCLC_SRS_BIT = 27;              // printed bit 4
  localparam int FCLC_UAE_BIT = 26;              // printed bit 5
  localparam int FCLC_CEN_HI = 25;               // printed bits 6:7
  localparam int FCLC_CEN_LO = 24;
  localparam int FCLC_SUP_HI = 23;               // printed bits 8:15
  localparam int FCLC_SUP_LO = 16;
  localparam int FCLC_DAT_HI = 15;               // printed bits 16:23
  localparam int FCLC_DAT_LO = 8;
  localparam int FCLC_PRT_HI = 7;                // printed bits 24:31
  localparam int FCLC_PRT_LO = 0;
  // control register fields (lsb-0)
  localparam int FCLC_SES_BIT = 0;
  localparam int FCLC_PE_BIT = 1;
  // reset values
  localparam logic FCLC_LOCK_RST = 1'h1;
  localparam logic [7:0] FCLC_SUP_RST = 8'hFF;
  localparam logic [7:0] FCLC_DAT_RST = 8'h00;
  localparam logic [7:0] FCLC_PRT_RST = 8'hFF;
  // array geometry
  localparam int FCLC_BLOCKS = 8;
  localparam int FCLC_SHADOW_BYTES = 256;
  localparam int FCLC_SHADOW_AW = $clog2(FCLC_SHADOW_BYTES);
  // array access request and answer
  typedef struct packed {
    logic valid;      // one access request this cycle
    logic [2:0] blk;  // array block index
    logic user;       // user mode access
    logic instr;      // instruction fetch
  } fclc_req_t;
  typedef struct packed {
    logic grant;      // access reaches the array
    logic shadow;     // redirected to the shadow row
    logic data_err;   // data error exception
  } fclc_ans_t;
endpackage

// >>> fclc_top.sv
// module: configuration lock, censorship and block mapping for a flash array
//
// Decided for this implementation: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
// What this block does
// [R1] lock bit at 0 blocks writes to force censor, supervisor, data, protect
// [R2] once cleared, lock stays cleared until master reset outside debug
// [R3] lock bit writable in background debug mode when censor-clear flag is 0
// [R4] lock bit sits at bit 0, 1 means writable, resets to 1
// [R5] software clears protect bits before clearing the lock bit
// [R6] force censor bit at bit 3 sticks at 1 until hard reset
// [R7] force censor set means information censorship unless uncensored enable
// [R8] shadow select at bit 4 ignores writes while sequence on and not erase
// [R9] shadow select at 1 steers array accesses to the shadow row; the code redirects only accesses to block 0
// [R10] uncensored enable at bit 5 ignores writes when censor-clear is 1
// [R11] uncensored enable 0 permits censored access only in no-censor state
// [R12] censor state bits 6:7 reset from two non-volatile bits
// [R13] censor 00 cleared: access only uncensored mode or enable set
// [R14] censor 01 and 10 mean no censorship, all accesses allowed
// [R15] censor 11 information censorship: uncensored mode or enable only
// [R16] supervisor map bits 8:15, user access to mapped block is data error
// [R17] supervisor map writes ignored while locked or censor-clear set
// [R18] supervisor map bit 1 means supervisor only, resets to 1
// [R19] sequence starts on the write moving sequence flag from 0 to 1
// [R20] shadow row is 256 bytes in the lowest array block
// [R21] map index k is block k, index 0 at the field msb
module fclc_top
  import fclc_pkg::*;
(
  // clock and resets
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hard_rst_i,
  input wire logic master_rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // device state
  input wire logic [1:0] nvm_censor_i,
  input wire logic debug_mode_i,
  input wire logic uncensored_mode_i,
  input wire logic censor_clear_flag_i,
  // array access
  input fclc_req_t req_i,
  output fclc_ans_t ans_o,
  output logic [7:0] protect_o,
  output logic [7:0] data_space_o
);

  ////////////////////////////////////////////////////////////////////////////
  logic lock_q, fic_q, srs_q, uae_q, ack_q, err_q, ses_q, pe_q;
  logic [1:0] cen_q;
  logic [7:0] sup_q, dat_q, prt_q;
  logic [31:0] rd_q, cfg_w, wmask;
  fclc_ans_t ans_q;
  logic req_new, wr, wr_cfg, wr_ctl, censored_ok;

  // a request is answered once; ack drops the cycle after it was given
  assign req_new = cyc_i && stb_i && !ack_q && !err_q;
  assign wr = req_new && we_i;
  assign wr_cfg = wr && adr_i == FCLC_CFG_OFF;
  assign wr_ctl = wr && adr_i == FCLC_CTL_OFF;

  // byte enables expanded to a bit mask
  for (genvar b = 0; b < 4; b++) begin : g_mask
    assign wmask[b*8 +: 8] = {8{sel_i[b]}};
  end

  assign cfg_w = {lock_q, 2'h0, fic_q, srs_q, uae_q, cen_q, sup_q, dat_q,
                  prt_q};

  ////////////////////////////////////////////////////////////////////////////
  // bus answer: one cycle latency, unmapped offsets answer with err
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      rd_q <= 32'h0;
    end else begin
      ack_q <= req_new && adr_i <= FCLC_STAT_OFF && adr_i[1:0] == 2'h0;
      err_q <= req_new && !(adr_i <= FCLC_STAT_OFF && adr_i[1:0] == 2'h0);
      if (req_new) begin
        unique case (adr_i)
          FCLC_CFG_OFF: rd_q <= cfg_w;
          FCLC_CTL_OFF: rd_q <= {30'h0, pe_q, ses_q};
          FCLC_STAT_OFF: rd_q <= {29'h0, ans_q};
          default: rd_q <= 32'h0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lock bit: only a master reset restores it outside debug mode
  always_ff @(posedge clk_i) begin
    if (master_rst_i) begin
      lock_q <= FCLC_LOCK_RST;
    // [R3] debug mode write
    end else if (wr_cfg && sel_i[3] && debug_mode_i && !censor_clear_flag_i)
    begin
      lock_q <= dat_i[FCLC_LOCK_BIT];
    // [R2] clear only, no reset
    end else if (wr_cfg && sel_i[3] && !debug_mode_i) begin
      // [R4] one keeps fields writable
      lock_q <= lock_q & dat_i[FCLC_LOCK_BIT];
    end
  end

  // force censor sticks; a hard reset is the only way back to zero
  always_ff @(posedge clk_i) begin
    if (hard_rst_i) begin
      fic_q <= 1'b0;
    // [R6] sticky force censor
    end else if (wr_cfg && sel_i[3] && lock_q) begin
      // [R1] locked write ignored
      fic_q <= fic_q | dat_i[FCLC_FIC_BIT];
    end
  end

  // censor state is captured from the fuses at reset, never a constant
  always_ff @(posedge clk_i) begin
    // [R12] fuse reset value
    if (rst_i) begin
      cen_q <= nvm_censor_i;
    end
  end

  // shadow select and uncensored enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      srs_q <= 1'b0;
      uae_q <= 1'b0;
    end else if (wr_cfg && sel_i[3]) begin
      // [R8] sequence guard
      if (!(ses_q && !pe_q)) begin
        srs_q <= dat_i[FCLC_SRS_BIT];
      end
      // [R10] set only uncensored
      if (!censor_clear_flag_i &&
          (uncensored_mode_i || !dat_i[FCLC_UAE_BIT])) begin
        uae_q <= dat_i[FCLC_UAE_BIT];
      end
    end
  end

  // mapping, data space and protect fields share the lock gate
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sup_q <= FCLC_SUP_RST;
      dat_q <= FCLC_DAT_RST;
      prt_q <= FCLC_PRT_RST;
    // [R1] [R17] locked field gate
    end else if (wr_cfg && lock_q && !censor_clear_flag_i) begin
      if (sel_i[2]) begin
        sup_q <= dat_i[FCLC_SUP_HI:FCLC_SUP_LO];
      end
      if (sel_i[1]) begin
        dat_q <= dat_i[FCLC_DAT_HI:FCLC_DAT_LO];
      end
      if (sel_i[0] && !ses_q) begin
        prt_q <= dat_i[FCLC_PRT_HI:FCLC_PRT_LO];
      end
    end
  end

  // sequence control; a 0 to 1 write of the enable flag begins a sequence
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ses_q <= 1'b0;
      pe_q <= 1'b0;
    // [R19] sequence start write
    end else if (wr_ctl && sel_i[0]) begin
      ses_q <= dat_i[FCLC_SES_BIT];
      if (!ses_q) begin
        pe_q <= dat_i[FCLC_PE_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // censorship decision
  always_comb begin
    // [R7] [R11] [R13] [R14] [R15] censorship table
    if (uae_q || uncensored_mode_i) begin
      censored_ok = 1'b1;
    end else begin
      censored_ok = !fic_q && (cen_q[1] != cen_q[0]);
    end
  end

  // array answer registered; block k maps to field bit 7-k
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ans_q <= '0;
    end else begin
      // [R16] [R18] [R21] supervisor map check
      ans_q.data_err <= req_i.valid && req_i.user && sup_q[3'h7 - req_i.blk];
      ans_q.grant <= req_i.valid && censored_ok &&
                     !(req_i.user && sup_q[3'h7 - req_i.blk]) &&
                     !(req_i.instr && dat_q[3'h7 - req_i.blk]);
      // [R9] [R20] shadow row in block 0
      ans_q.shadow <= req_i.valid && srs_q && req_i.blk == 3'h0;
    end
  end

  assign dat_o = rd_q;
  assign ack_o = ack_q;
  assign err_o = err_q;
  assign ans_o = ans_q;
  assign protect_o = prt_q;
  assign data_space_o = dat_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks: each sticky bit is watched with the one reset that may undo it
  lock_sticky_a: assert property ( // [R2]
    @(posedge clk_i) disable iff (master_rst_i)
    !lock_q && !debug_mode_i |=> !lock_q)
    else $error("lock bit set again outside debug mode");
  lock_reset_a: assert property ( // [R4]
    @(posedge clk_i)
    master_rst_i |=> lock_q)
    else $error("lock bit not restored by master reset");
  lock_debug_a: assert property ( // [R3]
    @(posedge clk_i) disable iff (master_rst_i)
    wr_cfg && sel_i[3] && debug_mode_i && !censor_clear_flag_i
    |=> lock_q == $past(dat_i[31]))
    else $error("debug mode write to lock bit lost");
  fic_sticky_a: assert property ( // [R6]
    @(posedge clk_i) disable iff (hard_rst_i)
    fic_q |=> fic_q)
    else $error("force censor cleared without hard reset");
  fic_reset_a: assert property ( // [R6]
    @(posedge clk_i)
    hard_rst_i |=> !fic_q)
    else $error("force censor not cleared by hard reset");
  fic_locked_a: assert property ( // [R1]
    @(posedge clk_i) disable iff (hard_rst_i)
    !lock_q && !fic_q |=> !fic_q)
    else $error("force censor written while locked");
  sup_locked_a: assert property ( // [R17]
    @(posedge clk_i) disable iff (rst_i)
    (!lock_q || censor_clear_flag_i) |=> $stable(sup_q))
    else $error("supervisor map changed while locked");
  prt_locked_a: assert property ( // [R1]
    @(posedge clk_i) disable iff (rst_i)
    (!lock_q || censor_clear_flag_i) |=> $stable(prt_q) && $stable(dat_q))
    else $error("protect or data space changed while locked");
  // fields with write conditions of their own
  srs_guard_a: assert property ( // [R8]
    @(posedge clk_i) disable iff (rst_i)
    ses_q && !pe_q |=> $stable(srs_q))
    else $error("shadow select written during sequence");
  uae_guard_a: assert property ( // [R10]
    @(posedge clk_i) disable iff (rst_i)
    censor_clear_flag_i |=> $stable(uae_q))
    else $error("uncensored enable written under censor clear");
  uae_mode_a: assert property ( // [R10]
    @(posedge clk_i) disable iff (rst_i)
    !uncensored_mode_i |=> !$rose(uae_q))
    else $error("uncensored enable set outside uncensored mode");
  cen_fuse_a: assert property ( // [R12]
    @(posedge clk_i)
    rst_i |=> cen_q == $past(nvm_censor_i))
    else $error("censor state not taken from the fuses");
  pe_hold_a: assert property ( // [R19]
    @(posedge clk_i) disable iff (rst_i)
    ses_q |=> $stable(pe_q))
    else $error("program erase select changed inside a sequence");
  // array answer, one cycle after the request
  user_err_a: assert property ( // [R16] [R21]
    @(posedge clk_i) disable iff (rst_i)
    req_i.valid && req_i.user && sup_q[3'h7 - req_i.blk]
    |=> ans_o.data_err && !ans_o.grant)
    else $error("user access to supervisor block not refused");
  sup_open_a: assert property ( // [R18]
    @(posedge clk_i) disable iff (rst_i)
    req_i.valid && !sup_q[3'h7 - req_i.blk] |=> !ans_o.data_err)
    else $error("data error on an unrestricted block");
  censor_grant_a: assert property ( // [R13] [R15]
    @(posedge clk_i) disable iff (rst_i)
    req_i.valid && !uae_q && !uncensored_mode_i && cen_q[1] == cen_q[0]
    |=> !ans_o.grant)
    else $error("censored array access granted");
  fic_grant_a: assert property ( // [R7]
    @(posedge clk_i) disable iff (rst_i)
    req_i.valid && fic_q && !uae_q && !uncensored_mode_i |=> !ans_o.grant)
    else $error("access granted under forced censorship");
  open_grant_a: assert property ( // [R11] [R14]
    @(posedge clk_i) disable iff (rst_i)
    req_i.valid && !req_i.user && !req_i.instr && !fic_q &&
    cen_q[1] != cen_q[0] |=> ans_o.grant)
    else $error("access refused with no censorship");
  uae_grant_a: assert property ( // [R7] [R11]
    @(posedge clk_i) disable iff (rst_i)
    req_i.valid && !req_i.user && !req_i.instr && uae_q |=> ans_o.grant)
    else $error("access refused with uncensored enable set");
  shadow_on_a: assert property ( // [R9] [R20]
    @(posedge clk_i) disable iff (rst_i)
    req_i.valid && srs_q && req_i.blk == 3'h0 |=> ans_o.shadow)
    else $error("shadow row not selected");
  shadow_off_a: assert property ( // [R9]
    @(posedge clk_i) disable iff (rst_i)
    !srs_q |=> !ans_o.shadow)
    else $error("shadow row selected while disabled");
  // bus answer
  bus_ack_a: assert property ( // bus contract
    @(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held two cycles");
  // main scenarios reached
  lock_clear_c: cover property (@(posedge clk_i) $fell(lock_q));
  user_err_c: cover property (@(posedge clk_i) ans_o.data_err);
  shadow_c: cover property (@(posedge clk_i) ans_o.shadow);
  grant_c: cover property (@(posedge clk_i) ans_o.grant);
  seq_start_c: cover property (@(posedge clk_i) $rose(ses_q));
endmodule // fclc_top

// >>> fclc_core_model.sv
// processor core model: issues array requests and captures the answers
`timescale 1ns/1ps
module fclc_core_model
  import fclc_pkg::*;
(
  // clock
  input wire logic clk_i,
  // array access
  output fclc_req_t req_o,
  input fclc_ans_t ans_i
);
  fclc_ans_t ans_q;
  initial req_o = '0;
  ////////////////////////////////////////////////////////////////////////////
  // one-cycle request, answer sampled in the following cycle only
  task automatic access(input logic [2:0] b, input logic u, input logic i);
    @(posedge clk_i);
    req_o <= '{valid: 1'b1, blk: b, user: u, instr: i};
    @(posedge clk_i);
    // released request: block and mode flip so stale values never pass
    req_o <= '{valid: 1'b0, blk: ~b, user: ~u, instr: ~i};
    @(posedge clk_i);
    ans_q = ans_i;
  endtask
endmodule // fclc_core_model

// >>> testbench.sv
// self-checking bench for the config lock, censorship and block map
`timescale 1ns/1ps
module testbench;
  import fclc_pkg::*;
  logic clk_i, rst_i, hard_rst_i, master_rst_i, cyc_i, stb_i, we_i;
  logic [3:0] adr_i, sel_i;
  logic [31:0] dat_i, dat_o, rd;
  int seed;
  logic ack_o, err_o, got_err, debug_mode_i, uncensored_mode_i;
  logic censor_clear_flag_i;
  logic [1:0] nvm_censor_i, cs;
  logic [7:0] v, protect_o, data_space_o;
  fclc_req_t req_i;
  fclc_ans_t ans_o;
  int num_errors, cmp_count, cycles;
  fclc_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .hard_rst_i(hard_rst_i),
    .master_rst_i(master_rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .err_o(err_o), .nvm_censor_i(nvm_censor_i),
    .debug_mode_i(debug_mode_i), .uncensored_mode_i(uncensored_mode_i),
    .censor_clear_flag_i(censor_clear_flag_i), .req_i(req_i),
    .ans_o(ans_o), .protect_o(protect_o), .data_space_o(data_space_o));
  fclc_core_model core_u (.clk_i(clk_i), .req_o(req_i), .ans_i(ans_o));
  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] exp_rst(input logic [1:0] c);
    return 32'h80FF00FF | {6'h00, c, 24'h000000};
  endfunction
  function automatic logic exp_grant(input logic [1:0] c, input logic u);
    return u | (c[1] ^ c[0]);
  endfunction
  task automatic chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // classic cycle, held until ack or err is sampled high
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'h3, w, a, d};
    do @(posedge clk_i); while (!(ack_o | err_o));
    rd = dat_o;
    got_err = err_o;
    {cyc_i, stb_i, we_i} <= 3'h0;
  endtask
  task automatic cfgw(input logic [31:0] m, d);
    wb(1'b0, FCLC_CFG_OFF, 32'h0);
    wb(1'b1, FCLC_CFG_OFF, (rd & ~m) | d);
    wb(1'b0, FCLC_CFG_OFF, 32'h0);
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    seed = 32'h2CC4;
    {rst_i, hard_rst_i, master_rst_i, cyc_i, stb_i, we_i} = 6'h38;
    {adr_i, sel_i, dat_i, nvm_censor_i} = {8'h0F, 32'h0, 2'h1};
    {debug_mode_i, uncensored_mode_i, censor_clear_flag_i} = 3'h0;
    repeat (8) @(posedge clk_i);
    {hard_rst_i, master_rst_i} <= 2'h0;
    // fuse state reloads on each reset; decision follows it
    for (int c = 0; c < 4; c++) begin
      // last state is a no-censor one, so forced censorship shows later
      cs = c[1:0] ^ 2'h2;
      nvm_censor_i <= cs;
      uncensored_mode_i <= 1'($random(seed));
      rst_i <= 1'b1;
      @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, FCLC_CFG_OFF, 32'h0);
      chk(rd, exp_rst(cs));
      core_u.access(3'($random(seed)), 1'b0, 1'b0);
      chk(core_u.ans_q.grant, exp_grant(cs, uncensored_mode_i));
    end
    $display("test censor done");
    uncensored_mode_i <= 1'b1;
    v = 8'($random(seed));
    cfgw(32'h00FF0000, {8'h00, v, 16'h0});
    chk(rd[23:16], v);
    for (int k = 0; k < 8; k++) begin
      core_u.access(k[2:0], 1'b1, 1'b0);
      chk(core_u.ans_q.data_err, v[7 - k]);
    end
    $display("test map done");
    cfgw(32'h08000000, 32'h08000000);
    core_u.access(3'h0, 1'b0, 1'b0);
    chk(core_u.ans_q.shadow, 1'b1);
    core_u.access(3'h5, 1'b0, 1'b0);
    chk(core_u.ans_q.shadow, 1'b0);
    wb(1'b1, FCLC_CTL_OFF, 32'h1);
    wb(1'b0, FCLC_CTL_OFF, 32'h0);
    chk(rd, 32'h1);
    cfgw(32'h08000000, 32'h0);
    chk(rd[27], 1'b1);
    wb(1'b1, FCLC_CTL_OFF, 32'h0);
    cfgw(32'h08000000, 32'h0);
    chk(rd[27], 1'b0);
    $display("test shadow done");
    uncensored_mode_i <= 1'b0;
    cfgw(32'h04000000, 32'h04000000);
    chk(rd[26], 1'b0);
    {uncensored_mode_i, censor_clear_flag_i} <= 2'h3;
    cfgw(32'h04000000, 32'h04000000);
    chk(rd[26], 1'b0);
    censor_clear_flag_i <= 1'b0;
    cfgw(32'h04000000, 32'h04000000);
    chk(rd[26], 1'b1);
    cfgw(32'h10000000, 32'h10000000);
    uncensored_mode_i <= 1'b0;
    core_u.access(3'h2, 1'b0, 1'b0);
    chk(core_u.ans_q.grant, 1'b1);
    cfgw(32'h04000000, 32'h0);
    core_u.access(3'h2, 1'b0, 1'b0);
    chk(core_u.ans_q.grant, 1'b0);
    cfgw(32'h10000000, 32'h0);
    chk(rd[28], 1'b1);
    $display("test censor force done");
    // protect cleared before the lock bit is cleared
    cfgw(32'h0000FFFF, 32'h00004000);
    chk({protect_o, data_space_o}, 16'h0040);
    cfgw(32'h80000000, 32'h0);
    v = rd[23:16];
    cfgw(32'h10FFFFFF, {8'h00, ~v, 16'h00FF});
    chk(rd[23:16], v);
    chk({protect_o, data_space_o}, 16'h0040);
    cfgw(32'h80000000, 32'h80000000);
    chk(rd[31], 1'b0);
    debug_mode_i <= 1'b1;
    cfgw(32'h80000000, 32'h80000000);
    chk(rd[31], 1'b1);
    debug_mode_i <= 1'b0;
    wb(1'b0, 4'hC, 32'h0);
    chk(got_err, 1'b1);
    $display("test lock done");
    end_sim();
  end
endmodule // testbench
